// *** design/ogp_driver.sv ***
// Device end: single-wire receiver, cascade output and three-channel PWM
// Function
// - Outputs off until non-zero data latched
// - PWM counter uses internal reference clock
// - Output on while counter not above value
// - Value N gives N periods; zero off
// - Measure bit period from first two edges
// - Host bit period 0.33 to 10 us
// - Measurement shifts two zero bits
// - No edge by 0.9 period: zero; code has no 0.9 timer, zero is no edge before half period
// - Edge before half period: one
// - Host sends 46 cells after measurement
// - Host ends packet with low hold
// - End of packet freezes, then forwards
// - Long low copies register into latch
// - Copy only when command equals 3AAh
// - Host sends command and data MSB first
// - Host sends N packets then latch
// - Host keeps one bit period per chain
// - Host resends whole chain on change
// - Latch resets counter, forces outputs off
// - Counter advances once per reference clock
// - Bits 0-11 sink_output_two, 12-23 sink_output_one, 24-35 sink_output_zero
`timescale 1ns/1ps
`include "ogp_consts.svh"
module ogp_driver
   import ogp_pkg::*;
(
   input wire logic mclk_in,
   input wire logic resetn_in,
   ogp_link_if.dev link,
   output logic serial_out,
   output logic sink_output_zero,
   output logic sink_output_one,
   output logic sink_output_two,
   output logic [`OGP_PKT_BITS-1:0] shift_value_out,
   output logic latch_pulse_out
);
   typedef struct packed {
      logic [1:0] sync;
      logic prev;
      ogp_rx_state_type st;
      logic [`OGP_PER_W-1:0] per;
      logic [`OGP_PER_W+3:0] cnt;
      logic [`OGP_PER_W+3:0] low;
      logic got_one;
      logic meas;
      logic [`OGP_PKT_BITS-1:0] sh;
      logic [`OGP_DATA_BITS-1:0] gray;
      logic [`OGP_GS_BITS-1:0] gcnt;
      logic [1:0] div;
      logic [2:0] outs;
      logic fwd;
      logic lat;
   } ogp_drv_st_type;

   ogp_drv_st_type s_r;
   ogp_drv_st_type s_nxt;

   logic rise;
   logic late_rise;
   logic lock_now;
   logic latch_now;
   logic cmd_ok;
   logic ref_tick;
   logic [`OGP_PER_W+3:0] per_w;
   logic [`OGP_GS_BITS-1:0] gcnt_step;
   logic [`OGP_GS_BITS-1:0] level [3];
   logic [2:0] outs_step;

   assign rise = s_r.sync[1] && !s_r.prev;
   // Edges before half a period are the one marks inside a cell
   assign late_rise = rise && (s_r.cnt >= (per_w >> 1));
   assign lock_now = (s_r.low >= per_w * (`OGP_PER_W + 4)'(`OGP_EOP_MULT));
   assign latch_now = (s_r.low == per_w * (`OGP_PER_W + 4)'(`OGP_LAT_MULT));
   assign cmd_ok = (s_r.sh[`OGP_PKT_BITS-1:`OGP_CMD_LSB] == `OGP_WRITE_CMD);
   assign ref_tick = (s_r.div == 2'(`OGP_REF_DIV - 1));
   assign gcnt_step = s_r.gcnt + 1'b1;
   assign per_w = {4'h0, s_r.per};
   assign level[0] = s_r.gray[`OGP_SINK_OUTPUT_ZERO_LSB +: `OGP_GS_BITS];
   assign level[1] = s_r.gray[`OGP_SINK_OUTPUT_ONE_LSB +: `OGP_GS_BITS];
   assign level[2] = s_r.gray[`OGP_SINK_OUTPUT_TWO_LSB +: `OGP_GS_BITS];

   assign serial_out = s_r.fwd;
   assign {sink_output_two, sink_output_one, sink_output_zero} = s_r.outs;
   assign shift_value_out = s_r.sh;
   assign latch_pulse_out = s_r.lat;

   // Counter zero is the off slot; a zero level never turns on
   for (genvar g = 0; g < 3; g++) begin : g_chan
      assign outs_step[g] = (level[g] != '0) && (gcnt_step != '0) &&
                            (gcnt_step <= level[g]);
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_nxt = s_r;
      s_nxt.sync = {s_r.sync[0], link.serial_line};
      s_nxt.prev = s_r.sync[1];
      s_nxt.lat = 1'b0;
      s_nxt.fwd = 1'b0;

      // Low time counts in every state; saturates rather than wraps
      if (s_r.sync[1]) begin
         s_nxt.low = '0;
      end else if (s_r.low != '1) begin
         s_nxt.low = s_r.low + 1'b1;
      end
      if (s_r.cnt != '1) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end

      case (s_r.st)
         RX_MEASURE: begin
            if (rise) begin
               s_nxt.cnt = (`OGP_PER_W + 4)'(1);
               s_nxt.st = RX_WAIT;
            end
         end

         RX_WAIT: begin
            if (rise) begin
               s_nxt.per = s_r.cnt[`OGP_PER_W-1:0];
               // Both measure cells are accounted for here
               s_nxt.sh = {s_r.sh[`OGP_PKT_BITS-3:0], 2'b00};
               s_nxt.meas = 1'b1;
               s_nxt.cnt = (`OGP_PER_W + 4)'(1);
               s_nxt.got_one = 1'b0;
               s_nxt.st = RX_CELL;
            end
         end

         RX_CELL: begin
            if (rise && !late_rise) begin
               s_nxt.got_one = 1'b1;
            end else if (late_rise) begin
               // A late edge closes the cell before it, but not the second measure cell
               if (!s_r.meas) begin
                  s_nxt.sh = {s_r.sh[`OGP_PKT_BITS-2:0], s_r.got_one};
               end
               s_nxt.meas = 1'b0;
               s_nxt.got_one = 1'b0;
               s_nxt.cnt = (`OGP_PER_W + 4)'(1);
            end
            // Zero is the absence of an early mark; no separate 0.9 timer
            if (lock_now) begin
               if (!s_r.meas) begin
                  s_nxt.sh = {s_r.sh[`OGP_PKT_BITS-2:0], s_r.got_one};
               end
               s_nxt.meas = 1'b0;
               s_nxt.st = RX_LOCKED;
            end
         end

         RX_LOCKED: begin
            // Forwarded copy lags the line by the synchroniser and one register
            s_nxt.fwd = s_r.sync[1];
            if (latch_now) begin
               if (cmd_ok) begin
                  s_nxt.gray = s_r.sh[`OGP_DATA_BITS-1:0];
                  s_nxt.gcnt = '0;
                  s_nxt.div = '0;
                  s_nxt.outs = 3'b000;
                  s_nxt.lat = 1'b1;
               end
               s_nxt.st = RX_MEASURE;
            end
         end

         default: begin
            s_nxt.st = RX_MEASURE;
         end
      endcase

      ////////////////////////////////////////////////////////////////////////
      // Reference clock is an enable from a divider of the main clock
      if (!s_nxt.lat) begin
         s_nxt.div = ref_tick ? '0 : s_r.div + 1'b1;
         if (ref_tick) begin
            s_nxt.gcnt = gcnt_step;
            s_nxt.outs = outs_step;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         // Sinks off and an empty latch until the first valid packet
         s_r.sync <= '0;
         s_r.prev <= 1'b0;
         s_r.st <= RX_MEASURE;
         s_r.per <= '0;
         s_r.cnt <= '0;
         s_r.low <= '0;
         s_r.got_one <= 1'b0;
         s_r.meas <= 1'b0;
         s_r.sh <= '0;
         s_r.gray <= '0;
         s_r.gcnt <= '0;
         s_r.div <= '0;
         s_r.outs <= 3'b000;
         s_r.fwd <= 1'b0;
         s_r.lat <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// *** design/ogp_consts.svh ***
// Constants for the single-wire grayscale PWM link
`ifndef OGP_CONSTS_SVH
`define OGP_CONSTS_SVH
`define OGP_CLK_MHZ 50
`define OGP_PKT_BITS 48
`define OGP_GS_BITS 12
`define OGP_DATA_BITS 36
`define OGP_CMD_LSB 36
`define OGP_WRITE_CMD 12'h3aa
`define OGP_SINK_OUTPUT_TWO_LSB 0
`define OGP_SINK_OUTPUT_ONE_LSB 12
`define OGP_SINK_OUTPUT_ZERO_LSB 24
`define OGP_PER_W 16
`define OGP_PER_MIN_NS 330
`define OGP_PER_MAX_NS 10000
`define OGP_PER_MIN_CYC ((`OGP_PER_MIN_NS * `OGP_CLK_MHZ + 999) / 1000)
`define OGP_PER_MAX_CYC ((`OGP_PER_MAX_NS * `OGP_CLK_MHZ) / 1000)
`define OGP_REF_DIV 4
`define OGP_EOP_MULT 4
`define OGP_LAT_MULT 8
`define OGP_FIFO_DEPTH 4
`endif

// *** design/ogp_pkg.sv ***
// Types for the single-wire grayscale PWM link
package ogp_pkg;
   typedef enum logic [1:0] {RX_MEASURE, RX_WAIT, RX_CELL, RX_LOCKED} ogp_rx_state_type;
   typedef enum logic [2:0] {TX_IDLE, TX_HIGH, TX_LOW, TX_EOP, TX_LATCH} ogp_tx_state_type;
endpackage

// *** design/ogp_link_if.sv ***
// Single-wire link joining host and driver
`timescale 1ns/1ps
interface ogp_link_if;
   logic serial_line;
   modport host (output serial_line);
   modport dev (input serial_line);
endinterface

// *** design/ogp_fifo.sv ***
// Small valid/ready word FIFO
`timescale 1ns/1ps
module ogp_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 4
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;
   assign in_ready_out = (cnt_r != (AW + 1)'(DEPTH));
   assign out_valid_out = (cnt_r != '0);
   assign out_data_out = mem_r[rp_r];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            mem_r[wp_r] <= in_data_in;
            wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end
endmodule

// *** design/ogp_host.sv ***
// Host end: encodes queued packets onto the single wire
`timescale 1ns/1ps
`include "ogp_consts.svh"
module ogp_host
   import ogp_pkg::*;
(
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic [`OGP_PER_W-1:0] bit_period_in,
   input wire logic pkt_valid_in,
   output logic pkt_ready_out,
   input wire logic [`OGP_PKT_BITS-1:0] pkt_data_in,
   input wire logic pkt_last_in,
   output logic busy_out,
   ogp_link_if.host link
);
   typedef struct packed {
      ogp_tx_state_type st;
      logic [`OGP_PKT_BITS-1:0] sh;
      logic [5:0] idx;
      logic [`OGP_PER_W-1:0] per;
      logic [`OGP_PER_W+3:0] cnt;
      logic second;
      logic last;
      logic line;
   } ogp_host_st_type;
   ogp_host_st_type s_r;
   ogp_host_st_type s_nxt;
   logic f_valid;
   logic f_pop;
   logic [`OGP_PKT_BITS:0] f_data;
   ogp_fifo #(.WIDTH(`OGP_PKT_BITS + 1), .DEPTH(`OGP_FIFO_DEPTH)) i_ogp_fifo (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .in_valid_in(pkt_valid_in),
      .in_ready_out(pkt_ready_out),
      .in_data_in({pkt_last_in, pkt_data_in}),
      .out_valid_out(f_valid),
      .out_ready_in(f_pop),
      .out_data_out(f_data)
   );
   assign f_pop = (s_r.st == TX_IDLE) && f_valid;
   assign link.serial_line = s_r.line;
   assign busy_out = (s_r.st != TX_IDLE);
   always_comb begin
      s_nxt = s_r;
      s_nxt.line = 1'b0;
      case (s_r.st)
         TX_IDLE: begin
            if (f_valid) begin
               // The measure cells stand in for the two top command bits
               s_nxt.sh = {f_data[`OGP_PKT_BITS-3:0], 2'b00};
               s_nxt.last = f_data[`OGP_PKT_BITS];
               // Clamp keeps the period in the decodable range
               if (bit_period_in < `OGP_PER_W'(`OGP_PER_MIN_CYC)) begin
                  s_nxt.per = `OGP_PER_W'(`OGP_PER_MIN_CYC);
               end else if (bit_period_in > `OGP_PER_W'(`OGP_PER_MAX_CYC)) begin
                  s_nxt.per = `OGP_PER_W'(`OGP_PER_MAX_CYC);
               end else begin
                  s_nxt.per = bit_period_in;
               end
               s_nxt.idx = 6'd0;
               s_nxt.cnt = '0;
               s_nxt.second = 1'b0;
               s_nxt.st = TX_HIGH;
            end
         end
         TX_HIGH: begin
            // First edge of each cell, one clock wide
            s_nxt.line = 1'b1;
            s_nxt.cnt = (`OGP_PER_W + 4)'(1);
            s_nxt.st = TX_LOW;
         end
         TX_LOW: begin
            s_nxt.cnt = s_r.cnt + 1'b1;
            // MSB first; a one puts a second edge at a quarter period
            if (!s_r.second && s_r.sh[`OGP_PKT_BITS-1] && s_r.idx >= 6'd2 &&
                s_r.cnt == {4'h0, s_r.per >> 2}) begin
               s_nxt.line = 1'b1;
               s_nxt.second = 1'b1;
            end
            if (s_r.cnt >= {4'h0, s_r.per} - 1'b1) begin
               s_nxt.second = 1'b0;
               // First two cells are the period measurement
               if (s_r.idx >= 6'd2) begin
                  s_nxt.sh = {s_r.sh[`OGP_PKT_BITS-2:0], 1'b0};
               end
               s_nxt.idx = s_r.idx + 1'b1;
               // Two measure cells plus 46 data cells
               if (s_r.idx == 6'(`OGP_PKT_BITS - 1)) begin
                  s_nxt.st = TX_EOP;
               end else begin
                  s_nxt.st = TX_HIGH;
               end
               s_nxt.cnt = '0;
            end
         end
         TX_EOP: begin
            s_nxt.cnt = s_r.cnt + 1'b1;
            if (s_r.cnt >= {4'h0, s_r.per} * (`OGP_PER_W + 4)'(`OGP_EOP_MULT + 1)) begin
               s_nxt.cnt = '0;
               s_nxt.st = s_r.last ? TX_LATCH : TX_IDLE;
            end
         end
         TX_LATCH: begin
            s_nxt.cnt = s_r.cnt + 1'b1;
            if (s_r.cnt >= {4'h0, s_r.per} * (`OGP_PER_W + 4)'(`OGP_LAT_MULT + 1)) begin
               s_nxt.st = TX_IDLE;
            end
         end
         default: s_nxt.st = TX_IDLE;
      endcase
   end
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         s_r <= '{st: TX_IDLE, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// *** verif/ogp_properties.sv ***
// Checker for the host to driver link and PWM outputs
`timescale 1ns/1ps
`include "ogp_consts.svh"
module ogp_properties (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic serial_line,
   input wire logic busy_out,
   input wire logic serial_out,
   input wire logic sink_output_zero,
   input wire logic sink_output_one,
   input wire logic sink_output_two,
   input wire logic [`OGP_PKT_BITS-1:0] shift_value_out,
   input wire logic latch_pulse_out
);
   typedef struct packed {logic [10:0] low; logic seen; logic [35:0] lat;} ogp_chk_type;
   ogp_chk_type st_r;
   ogp_chk_type st_nxt;
   logic any_on;
   assign any_on = sink_output_zero | sink_output_one | sink_output_two;
   ////////////////////////////////////////
   // Low run length saturates so idle lines never wrap
   always_comb begin
      st_nxt = st_r;
      st_nxt.low = serial_line ? 11'h000 : st_r.low + {10'h000, st_r.low != 11'h7ff};
      if (latch_pulse_out) begin
         st_nxt.seen = 1'b1;
         st_nxt.lat = shift_value_out[35:0];
      end
      if (!resetn_in) st_nxt = '0;
   end
   always_ff @(posedge mclk_in) st_r <= st_nxt;
   ////////////////////////////////////////
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   a_off_before_latch: assert property (!st_r.seen |-> !any_on)
      else $error("output on before any latch");
   a_zero_stays_off: assert property (st_r.seen && st_r.lat[11:0] == 12'h000 |-> !sink_output_two)
      else $error("zero channel turned on");
   a_common_turn_on: assert property ($rose(sink_output_zero) && st_r.lat[23:12] != 12'h000
      |-> sink_output_one)
      else $error("channels did not turn on together");
   a_latch_cmd_ok: assert property (latch_pulse_out
      |-> shift_value_out[47:36] == `OGP_WRITE_CMD)
      else $error("latch with wrong command");
   a_latch_single: assert property (latch_pulse_out |=> !latch_pulse_out)
      else $error("latch pulse too long");
   a_latch_forces_off: assert property (latch_pulse_out |=> !any_on)
      else $error("output on right after latch");
   a_latch_long_low: assert property (latch_pulse_out |-> st_r.low >= 11'd100)
      else $error("latch after short low");
   a_shift_frozen: assert property (st_r.low >= 11'd1000 |-> $stable(shift_value_out))
      else $error("shift value moved on idle line");
   a_forward_follows: assert property ($rose(serial_out) |-> st_r.low < 11'd16)
      else $error("forwarded edge without input edge");
   a_idle_line_low: assert property (!busy_out |-> !serial_line)
      else $error("line high while host idle");
   c_latch: cover property (latch_pulse_out);
   c_forward: cover property ($rose(serial_out));
   c_sink_on: cover property ($rose(sink_output_zero));
endmodule

// *** verif/testbench.sv ***
// Self-checking bench: host and driver joined by the link
`timescale 1ns/1ps
module testbench;
   logic mclk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic pkt_valid = 1'b0;
   logic pkt_last = 1'b0;
   logic [47:0] pkt_data = '0;
   logic [15:0] bit_period = 16'd20;
   logic pkt_ready, busy, serial_out, s0, s1, s2, lpulse;
   logic so_q = 1'b0;
   logic [47:0] shv;
   logic [47:0] pk [5];
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   int n_lat = 0;
   int n_fwd = 0;
   int exp_fwd = 0;
   int on_cnt [3] = '{0, 0, 0};
   ogp_link_if link ();
   ogp_host i_ogp_host (.mclk_in(mclk_in), .resetn_in(resetn_in), .bit_period_in(bit_period),
      .pkt_valid_in(pkt_valid), .pkt_ready_out(pkt_ready), .pkt_data_in(pkt_data),
      .pkt_last_in(pkt_last), .busy_out(busy), .link(link));
   ogp_driver i_ogp_driver (.mclk_in(mclk_in), .resetn_in(resetn_in), .link(link),
      .serial_out(serial_out), .sink_output_zero(s0), .sink_output_one(s1),
      .sink_output_two(s2), .shift_value_out(shv), .latch_pulse_out(lpulse));
   ogp_properties i_ogp_properties (.mclk_in(mclk_in), .resetn_in(resetn_in),
      .serial_line(link.serial_line), .busy_out(busy), .serial_out(serial_out),
      .sink_output_zero(s0), .sink_output_one(s1), .sink_output_two(s2),
      .shift_value_out(shv), .latch_pulse_out(lpulse));
   always #10 mclk_in = ~mclk_in;
   ////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(string what, logic [47:0] seen, logic [47:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Leaves valid high so pushes run back to back
   task automatic push(logic [47:0] d, logic l);
      int k;
      k = 0;
      pkt_data = d;
      pkt_last = l;
      pkt_valid = 1'b1;
      while (pkt_ready !== 1'b1 && k < 5000) begin
         @(negedge mclk_in);
         k++;
      end
      @(negedge mclk_in);
   endtask
   // Busy drops for one cycle between queued packets, so wait for a quiet run
   task automatic idle();
      int k;
      int q;
      k = 0;
      q = 0;
      pkt_valid = 1'b0;
      while (q < 4 && k < 40000) begin
         @(negedge mclk_in);
         k++;
         q = (busy === 1'b0) ? q + 1 : 0;
      end
      repeat (10) @(negedge mclk_in);
   endtask
   // Window of one full PWM period: 4096 ticks of 4 clocks
   task automatic pwm(int e0, int e1, int e2);
      on_cnt = '{0, 0, 0};
      repeat (16384) @(negedge mclk_in);
      check("on_time_sink_output_zero", on_cnt[0], 4 * e0);
      check("on_time_sink_output_one", on_cnt[1], 4 * e1);
      check("on_time_sink_output_two", on_cnt[2], 4 * e2);
   endtask
   ////////////////////////////////////////
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      so_q <= serial_out;
      if (lpulse === 1'b1) n_lat <= n_lat + 1;
      if (serial_out === 1'b1 && so_q === 1'b0) n_fwd <= n_fwd + 1;
      on_cnt[0] <= on_cnt[0] + int'(s0 === 1'b1);
      on_cnt[1] <= on_cnt[1] + int'(s1 === 1'b1);
      on_cnt[2] <= on_cnt[2] + int'(s2 === 1'b1);
      if (cyc == 60000) begin
         n_errors++;
         conclude();
      end
   end
   initial begin
      pk[0] = {12'h3aa, 12'hfff, 12'h001, 12'h000};
      for (int i = 1; i < 5; i++) begin
         pk[i] = {12'h3aa, 36'(i * 36'h123456789)};
         exp_fwd += 48 + $countones(pk[i][45:0]);
      end
      repeat (20) @(negedge mclk_in);
      resetn_in = 1'b1;
      @(negedge mclk_in);
      for (int i = 0; i < 5; i++) push(pk[i], i == 4);
      check("fifo_ready_when_full", pkt_ready, 48'h0);
      idle();
      check("latch_count", n_lat, 48'h1);
      check("shift_value", shv, pk[0]);
      check("forwarded_edges", n_fwd, exp_fwd);
      pwm(4095, 1, 0);
      n_lat = 0;
      push({12'h3ab, 36'h000001001}, 1'b1);
      idle();
      check("bad_cmd_latch", n_lat, 48'h0);
      check("bad_cmd_shift", shv, {12'h3ab, 36'h000001001});
      pwm(4095, 1, 0);
      conclude();
   end
endmodule
